// File: design/sbpc_consts.vh
// Constants for the serial bus pin control block.
// Included by the design files by bare name; definitions only.
`ifndef SBPC_CONSTS_VH
`define SBPC_CONSTS_VH

// Register offsets (byte addresses)
`define SBPC_OFS_DDC 16'h5010
`define SBPC_OFS_AUX 16'h5014
// Address width of the register port
`define SBPC_AW 16
// Field positions of the lower pin; upper pin sits 8 bits higher
`define SBPC_BIT_DIR_MASK 0
`define SBPC_BIT_DIR_VAL 1
`define SBPC_BIT_DAT_MASK 2
`define SBPC_BIT_DAT_VAL 3
`define SBPC_BIT_DAT_IN 4
`define SBPC_UPPER_SHIFT 5'h08
// Reset values of stored fields
`define SBPC_RST_BIT 1'b0
`define SBPC_RST_WORD 32'h0000_0000
// Number of pins
`define SBPC_NPINS 4

`endif

// File: design/sbpc_pin_sync.v
// Three-stage synchroniser for one pin input level.
// Assumes an asynchronous pin; output changes once stages 2 and 3 agree.
`timescale 1ns/100ps
`include "sbpc_consts.vh"

module sbpc_pin_sync
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pin level in, filtered level out
    input wire pin_in,
    output reg level
);

    // First stage is read only by the second stage
    reg stage1;
    // Second and third stage compared for agreement
    reg stage2;
    reg stage3;

    // Shift the pin through and update on agreement
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= `SBPC_RST_BIT;
            stage2 <= `SBPC_RST_BIT;
            stage3 <= `SBPC_RST_BIT;
            level <= `SBPC_RST_BIT;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // Agreement guards against a single metastable glitch
            if (stage2 == stage3)
            begin
                level <= stage3;
            end
        end
    end

endmodule

// File: design/sbpc_top.v
// Serial bus pin control: two registers steering four pins.
// Assumes a simple strobe register port on clk; pins are asynchronous.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "sbpc_consts.vh"

module sbpc_top
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Monitor bus clock pin
    input wire monitor_bus_clock_pin_in,
    output reg monitor_bus_clock_pin_out,
    output reg monitor_bus_clock_pin_oe,
    // Monitor bus data pin
    input wire monitor_bus_data_pin_in,
    output reg monitor_bus_data_pin_out,
    output reg monitor_bus_data_pin_oe,
    // Encoder bus clock pin
    input wire encoder_bus_clock_pin_in,
    output reg encoder_bus_clock_pin_out,
    output reg encoder_bus_clock_pin_oe,
    // Encoder bus data pin
    input wire encoder_bus_data_pin_in,
    output reg encoder_bus_data_pin_out,
    output reg encoder_bus_data_pin_oe
);

    // Stored output values, index 0..3 = ddc clk, ddc data, aux clk, aux data
    reg [`SBPC_NPINS-1:0] out_val;
    // Stored directions, one means driving
    reg [`SBPC_NPINS-1:0] dir_val;
    // Synchronised pin levels
    wire [`SBPC_NPINS-1:0] pin_level;
    // Raw pin inputs gathered
    wire [`SBPC_NPINS-1:0] pin_raw;
    // Write decode per pin
    reg [`SBPC_NPINS-1:0] pin_sel;
    // Next read word
    reg [31:0] next_rdata;
    // Loop index of the write process
    integer i;
    // Loop index of the read process; a shared index would have two drivers
    integer j;

    // Pins gathered in register order, lower pin of each register first
    assign pin_raw = {encoder_bus_data_pin_in, encoder_bus_clock_pin_in,
                      monitor_bus_data_pin_in, monitor_bus_clock_pin_in};

    // Bit offset of a pin's field within its register
    function [4:0] field_base;
        input integer pin;
        begin
            if (pin % 2 == 1)
            begin
                field_base = `SBPC_UPPER_SHIFT;
            end
            else
            begin
                field_base = 5'h00;
            end
        end
    endfunction

    // Register hit for a pin; the lower half of the pins sit in the first
    // register, so a write to one register never touches the other
    function reg_hit;
        input [15:0] adr;
        input integer pin;
        begin
            if (pin < `SBPC_NPINS / 2)
            begin
                reg_hit = (adr == `SBPC_OFS_DDC);
            end
            else
            begin
                reg_hit = (adr == `SBPC_OFS_AUX);
            end
        end
    endfunction

    // One synchroniser per pin for the input bits
    // Data-in bits lag the pin by four to five clocks through the filter
    genvar g;
    generate
        for (g = 0; g < `SBPC_NPINS; g = g + 1)
        begin : g_sync
            sbpc_pin_sync u_sync
            (
                .clk(clk),
                .rst_n(rst_n),
                .pin_in(pin_raw[g]),
                .level(pin_level[g])
            );
        end
    endgenerate

    // Register select per pin from the address
    always @*
    begin
        pin_sel[0] = reg_hit(addr, 0);
        pin_sel[1] = reg_hit(addr, 1);
        pin_sel[2] = reg_hit(addr, 2);
        pin_sel[3] = reg_hit(addr, 3);
    end

    // Masked writes of value and direction; a field whose mask is zero
    // keeps its stored bit, so software can turn one line at a time
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Every pin an input with a low value after reset
            out_val <= {`SBPC_NPINS{`SBPC_RST_BIT}};
            dir_val <= {`SBPC_NPINS{`SBPC_RST_BIT}};
        end
        else if (wr)
        begin
            for (i = 0; i < `SBPC_NPINS; i = i + 1)
            begin
                // Mask bits are strobes only, never stored
                if (pin_sel[i] &&
                    wdata[field_base(i) + `SBPC_BIT_DAT_MASK])
                begin
                    // Value bit taken only beside its mask
                    out_val[i] <=
                        wdata[field_base(i) + `SBPC_BIT_DAT_VAL];
                end
                if (pin_sel[i] &&
                    wdata[field_base(i) + `SBPC_BIT_DIR_MASK])
                begin
                    // Direction bit taken only beside its mask
                    dir_val[i] <=
                        wdata[field_base(i) + `SBPC_BIT_DIR_VAL];
                end
            end
        end
    end

    // Read word assembly; unmapped addresses read zero
    // Reserved bits are never stored, so they need no clearing here
    always @*
    begin
        next_rdata = `SBPC_RST_WORD;
        for (j = 0; j < `SBPC_NPINS; j = j + 1)
        begin
            if (pin_sel[j])
            begin
                // Mask bits stay zero; they are strobes only
                next_rdata[field_base(j) + `SBPC_BIT_DAT_IN] =
                    pin_level[j];
                next_rdata[field_base(j) + `SBPC_BIT_DAT_VAL] = out_val[j];
                next_rdata[field_base(j) + `SBPC_BIT_DIR_VAL] = dir_val[j];
            end
        end
    end

    // Read data register; stands only in the cycle after the strobe
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= `SBPC_RST_WORD;
        end
        else if (rd)
        begin
            rdata <= next_rdata;
        end
        else
        begin
            // Zero outside the answer cycle keeps the bus quiet
            rdata <= `SBPC_RST_WORD;
        end
    end

    // Pin drivers registered; writes reach the pin one cycle later.
    // The extra cycle keeps every pin output straight from a flop, so
    // no decode glitch ever reaches the bus lines.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            monitor_bus_clock_pin_out <= `SBPC_RST_BIT;
            monitor_bus_clock_pin_oe <= `SBPC_RST_BIT;
            monitor_bus_data_pin_out <= `SBPC_RST_BIT;
            monitor_bus_data_pin_oe <= `SBPC_RST_BIT;
            encoder_bus_clock_pin_out <= `SBPC_RST_BIT;
            encoder_bus_clock_pin_oe <= `SBPC_RST_BIT;
            encoder_bus_data_pin_out <= `SBPC_RST_BIT;
            encoder_bus_data_pin_oe <= `SBPC_RST_BIT;
        end
        else
        begin
            // Value gated by direction so an input pin shows nothing
            monitor_bus_clock_pin_out <= out_val[0] & dir_val[0];
            monitor_bus_clock_pin_oe <= dir_val[0];
            monitor_bus_data_pin_out <= out_val[1] & dir_val[1];
            monitor_bus_data_pin_oe <= dir_val[1];
            encoder_bus_clock_pin_out <= out_val[2] & dir_val[2];
            encoder_bus_clock_pin_oe <= dir_val[2];
            encoder_bus_data_pin_out <= out_val[3] & dir_val[3];
            encoder_bus_data_pin_oe <= dir_val[3];
        end
    end

endmodule

// File: dv/sbpc_bus_peer.sv
// Far side of the four serial lines, with pull-ups.
// Pin order: ddc clock, ddc data, encoder clock, encoder data.
`timescale 1ns/100ps
module sbpc_bus_peer
(
    // Frame control and forced lows
    input wire run,
    input wire [3:0] pull_low,
    // Design drive per pin
    input wire [3:0] oe,
    input wire [3:0] out,
    // Resolved line levels
    output wire [3:0] lvl
);
    reg sclk_low = 1'b0;
    // Peer clock, 160 ns, still outside frames
    always #80 sclk_low = run ? ~sclk_low : 1'b0;
    // Released lines float high
    assign lvl = (oe & out) | (~oe & ~(pull_low | {3'h0, sclk_low}));
endmodule

// File: dv/sbpc_chk.sv
// Assertions on the pin control block ports.
// Bound into the top; same clock and reset as the design.
`timescale 1ns/100ps
module sbpc_chk
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    // Pins watched
    input wire monitor_bus_clock_pin_out,
    input wire monitor_bus_clock_pin_oe,
    input wire monitor_bus_data_pin_in,
    input wire encoder_bus_data_pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read of the first register
    sequence ddc_rd;
        rd && addr == 16'h5010;
    endsequence
    // Pin held long enough to cross the synchroniser
    sequence dat_hi;
        monitor_bus_data_pin_in [*6];
    endsequence
    read_mask_a: assert property (rd |=> (rdata & 32'hFFFFE5E5) == 0)
        else $error("mask or reserved bit read back");
    reset_in_a: assert property ($rose(rst_n) |->
        !monitor_bus_clock_pin_oe && !encoder_bus_data_pin_oe)
        else $error("pin driven after reset");
    out_gate_a: assert property (!monitor_bus_clock_pin_oe |->
        !monitor_bus_clock_pin_out) else $error("input pin driven");
    dir_keep_a: assert property (wr && addr == 16'h5010 && !wdata[0] |=>
        ##1 $stable(monitor_bus_clock_pin_oe)) else $error("dir changed");
    dat_keep_a: assert property (wr && addr == 16'h5010 &&
        (wdata & 32'h5) == 0 |=> ##1 $stable(monitor_bus_clock_pin_out))
        else $error("value changed without mask");
    aux_on_a: assert property (wr && addr == 16'h5014 &&
        wdata[9:8] == 2'b11 |=> ##1 encoder_bus_data_pin_oe)
        else $error("upper aux pin not driven");
    pin_in_a: assert property (dat_hi ##0 ddc_rd |=> rdata[12])
        else $error("data in bit lost");
    wr_rd_a: assert property ((wr && addr == 16'h5010 && wdata[2])
        ##1 ddc_rd |=> rdata[3] == $past(wdata[3], 2))
        else $error("read after write stale");
endmodule

bind sbpc_top sbpc_chk chk_u
(
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .monitor_bus_clock_pin_out(monitor_bus_clock_pin_out),
    .monitor_bus_clock_pin_oe(monitor_bus_clock_pin_oe),
    .monitor_bus_data_pin_in(monitor_bus_data_pin_in),
    .encoder_bus_data_pin_oe(encoder_bus_data_pin_oe)
);

// File: dv/tb_top.sv
// Self-checking bench for the pin control block.
// Peer model resolves the pins; reads are noted in a queue.
`timescale 1ns/100ps
module tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [15:0] addr = 16'h0;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg run = 1'b0;
    reg [3:0] pull_low = 4'h0;
    wire [31:0] rdata;
    wire [3:0] oe, out, lvl;
    reg [31:0] sh [0:1];
    reg [31:0] exp_q [$];
    reg rd_seen = 1'b0;
    integer errors = 0, checks_done = 0, i;
    reg [31:0] d;
    reg [1:0] r;
    sbpc_top dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata),
        .monitor_bus_clock_pin_in(lvl[0]), .monitor_bus_clock_pin_out(out[0]),
        .monitor_bus_clock_pin_oe(oe[0]), .monitor_bus_data_pin_in(lvl[1]),
        .monitor_bus_data_pin_out(out[1]), .monitor_bus_data_pin_oe(oe[1]),
        .encoder_bus_clock_pin_in(lvl[2]), .encoder_bus_clock_pin_out(out[2]),
        .encoder_bus_clock_pin_oe(oe[2]), .encoder_bus_data_pin_in(lvl[3]),
        .encoder_bus_data_pin_out(out[3]), .encoder_bus_data_pin_oe(oe[3]));
    sbpc_bus_peer peer_u (.run(run), .pull_low(pull_low), .oe(oe),
        .out(out), .lvl(lvl));
    initial forever #10 clk = ~clk;
    task automatic check(input string nm, input [31:0] seen, input [31:0] e);
    begin
        checks_done = checks_done + 1;
        if (seen !== e)
        begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    end
    endtask
    // One strobe cycle; a read also notes its expected answer
    task automatic acc(input w, input [15:0] a, input [31:0] v,
        input [31:0] e);
    begin
        addr <= a;
        wdata <= v;
        if (w)
        begin
            wr <= 1'b1;
        end
        else
        begin
            exp_q.push_back(e);
            rd <= 1'b1;
        end
        @(posedge clk);
        if (w) wr <= 1'b0;
        else rd <= 1'b0;
    end
    endtask
    // Mask-gated update of the bench's copy
    task automatic store(input [1:0] n, input [31:0] w);
        integer k;
    begin
        for (k = 0; k < 9; k = k + 8)
        begin
            if (w[k]) sh[n][k+1] = w[k+1];
            if (w[k+2]) sh[n][k+3] = w[k+3];
        end
    end
    endtask
    function [31:0] rexp(input [1:0] n);
        rexp = n[1] ? 32'h0 : (sh[n[0]] & 32'h0A0A) |
            {lvl[{n[0], 1'b1}], 7'h0, lvl[{n[0], 1'b0}], 4'h0};
    endfunction
    // Pin outputs against the bench's copy of both registers only
    task pins;
        reg [3:0] dir_e;
        reg [3:0] val_e;
    begin
        dir_e = {sh[1][9], sh[1][1], sh[0][9], sh[0][1]};
        val_e = {sh[1][11], sh[1][3], sh[0][11], sh[0][3]};
        check("oe", oe, dir_e);
        check("out", out, dir_e & val_e);
    end
    endtask
    // Read answers compared one cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen) check("rdata", rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    task print_verdict;
    begin
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        errors = errors + 1;
        print_verdict;
    end
    initial
    begin
        void'($urandom(13));
        sh[0] = 32'h0;
        sh[1] = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        pins;
        // Data-in bits need four clocks through the pin filter
        repeat (4) @(posedge clk);
        acc(0, 16'h5010, 0, 32'h1010);
        @(posedge clk);
        acc(0, 16'h5014, 0, 32'h1010);
        $display("test reset done");
        for (i = 0; i < 40; i = i + 1)
        begin
            r = $urandom % 3;
            d = $urandom;
            pull_low <= $urandom;
            acc(1, 16'h5010 + 4 * r, d, 0);
            if (r < 2) store(r, d);
            repeat (8) @(posedge clk);
            pins;
            acc(0, 16'h5010 + 4 * r, 0, rexp(r));
        end
        $display("test random done");
        acc(1, 16'h5010, 32'h0505, 0);
        @(posedge clk);
        acc(1, 16'h5014, 32'h0505, 0);
        store(0, 32'h0505);
        store(1, 32'h0505);
        repeat (8) @(posedge clk);
        acc(1, 16'h5010, 32'h0C0C, 0);
        store(0, 32'h0C0C);
        acc(0, 16'h5010, 0, rexp(0));
        repeat (3) @(posedge clk);
        pins;
        run <= 1'b1;
        repeat (40) @(posedge clk);
        run <= 1'b0;
        repeat (8) @(posedge clk);
        acc(0, 16'h5010, 0, rexp(0));
        @(posedge clk);
        $display("test direct done");
        print_verdict;
    end
endmodule
